// File: inc/wake_pkg.sv
// Shared constants and types for the wake-up event controller and its host.
package wake_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_MHZ      = 250;
   localparam int WAKE_MAX_US  = 10000;
   localparam int WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;
   localparam int PULSE_NS     = 1000;
   localparam int PULSE_CYC    = PULSE_NS * CLK_MHZ / 1000;
   localparam logic [7:0] UNIT_LAST = 8'hff;  // 256 ticks per unit.
   // ****************************************************************
   // Wake source bits and event register
   // ****************************************************************
   localparam int SRC_TIMEOUT = 0;
   localparam int SRC_TAG     = 1;
   localparam int SRC_PIN     = 3;
   localparam int SRC_SS      = 4;
   localparam logic [7:0] WAKE_EVENT_ADDR = 8'h62;
   localparam logic [4:0] MAX_BURST_LO    = 5'h01;
   localparam logic [4:0] MAX_BURST_HI    = 5'h1e;
   localparam logic [7:0] CAL_HI_START    = 8'hfe;
   localparam logic [7:0] GUARD           = 8'h08;
   // ****************************************************************
   // Host register map
   // ****************************************************************
   localparam logic [4:0] REG_CTRL   = 5'h00;
   localparam logic [4:0] REG_SRC    = 5'h04;
   localparam logic [4:0] REG_TIME   = 5'h08;
   localparam logic [4:0] REG_DET    = 5'h0c;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam int CTRL_IDLE = 0;
   localparam int CTRL_WAKE = 1;
   localparam int CTRL_SS   = 2;
   localparam int CTRL_CAL  = 3;

   typedef struct packed {
      logic [7:0] src;
      logic       hib;
      logic [7:0] gap;
      logic [7:0] osc;
      logic [7:0] dac;
      logic [7:0] lo;
      logic [7:0] hi;
      logic [7:0] swings;
      logic [7:0] max_burst;
   } idle_cmd_t;
endpackage

// File: inc/wake_if.sv
// Link between the wake-up controller and its host.
`timescale 1ns/1ps
`default_nettype none
interface wake_if;
   import wake_pkg::*;
   logic       wake_n;
   logic       ss_n;
   logic       lfo_clk;
   logic       idle_valid;
   logic       idle_ready;
   logic       dev_ready;
   idle_cmd_t  idle_cmd;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   modport dev (input wake_n, ss_n, lfo_clk, idle_valid, idle_cmd,
      rd_addr, output idle_ready, dev_ready, rd_data);
   modport host (output wake_n, ss_n, idle_valid, idle_cmd, rd_addr,
      input idle_ready, dev_ready, rd_data, lfo_clk);
endinterface
`default_nettype wire

// File: logic/wake_dev.sv
// Device end: wait-for-event sequencer with timer and tag detection.
`timescale 1ns/1ps
`default_nettype none
module wake_dev
   import wake_pkg::*;
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Link to the host
   wake_if.dev             lnk,
   // Analog side
   input  wire logic [5:0] driver_current,
   output logic            high_freq_osc_en,
   output logic            spi_selected,
   output logic [5:0]      conv_data
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum logic [2:0] {
      S_PWRUP, S_READY, S_HIB, S_GAP, S_OSC, S_DAC, S_BURST
   } state_t;

   typedef struct packed {
      state_t     st;
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] pre;
      logic [7:0] tl;
      logic [8:0] unit;
      logic [4:0] bursts;
      logic [7:0] settle;
      logic [7:0] swing;
      idle_cmd_t  cmd;
      logic [5:0] conv;
      logic [7:0] ev;
      logic       high_freq_osc;
      logic       spi;
   } dev_t;

   dev_t       q;
   dev_t       d;
   logic       lfo_rise;
   logic       pin_pulse;
   logic       ss_pulse;
   logic [2:0] div_mask;
   logic       tick;
   logic       unit_end;
   logic       period_end;
   logic       last_burst;
   logic       hit;
   logic [7:0] meas;
   logic [7:0] wake;

   // ****************************************************************
   // Next state
   // ****************************************************************
   // The pins pass s1 and s2 before any decision; s3 only delays s2.
   always_comb begin
      d = q;
      wake = 8'h00;
      d.s1 = {lnk.ss_n, lnk.wake_n, lnk.lfo_clk};
      d.s2 = q.s1;
      d.s3 = q.s2;
      lfo_rise = q.s2[0] & ~q.s3[0];
      // A low pulse counts once it has ended, so glitches must be whole.
      pin_pulse = q.s2[1] & ~q.s3[1];
      ss_pulse = q.s2[2] & ~q.s3[2];
      // Source bits 7:6 pick 1, 2, 4 or 8 slow edges per tick.
      div_mask = 3'h7 >> (2'd3 - q.cmd.src[7:6]);
      tick = lfo_rise && ((q.pre & div_mask) == div_mask);
      if (lfo_rise) begin
         d.pre = q.pre + 3'd1;
      end
      unit_end = tick && (q.tl == UNIT_LAST);
      period_end = unit_end
         && (q.unit == {1'b0, q.cmd.gap} + 9'd1);
      last_burst = q.cmd.src[SRC_TIMEOUT]
         && (q.bursts == q.cmd.max_burst[4:0]);
      // Converter steps are four threshold counts wide.
      meas = {driver_current, 2'b00};
      hit = (meas > q.cmd.hi) || (meas < q.cmd.lo);
      if (q.st == S_GAP || q.st == S_OSC || q.st == S_DAC) begin
         if (tick) begin
            d.tl = q.tl + 8'd1;
         end
         if (unit_end) begin
            d.unit = period_end ? 9'd0 : q.unit + 9'd1;
         end
      end

      unique case (q.st)
         S_PWRUP: begin
            if (pin_pulse) begin
               d.st = S_READY;
               d.spi = 1'b1;
               d.high_freq_osc = 1'b1;
            end
         end
         S_READY: begin
            if (lnk.idle_valid) begin
               d.cmd = lnk.idle_cmd;
               // Only five bits of the burst limit take part.
               d.cmd.max_burst =
                  {3'b000, lnk.idle_cmd.max_burst[4:0]};
               d.high_freq_osc = 1'b0;
               d.tl = 8'h00;
               d.unit = 9'd0;
               d.bursts = 5'd0;
               d.st = lnk.idle_cmd.hib ? S_HIB : S_GAP;
            end
         end
         S_HIB: begin
            // Every other cause is dropped while hibernating.
            if (pin_pulse) begin
               wake[SRC_PIN] = 1'b1;
            end
         end
         S_GAP: begin
            if (period_end) begin
               if (q.cmd.src[SRC_TAG]) begin
                  d.st = S_OSC;
                  d.settle = 8'h00;
                  d.high_freq_osc = 1'b1;
               end else begin
                  d.bursts = q.bursts + 5'd1;
                  wake[SRC_TIMEOUT] = last_burst;
               end
            end
         end
         S_OSC: begin
            if (q.settle == q.cmd.osc) begin
               d.st = S_DAC;
               d.settle = 8'h00;
            end else if (tick) begin
               d.settle = q.settle + 8'd1;
            end
         end
         S_DAC: begin
            if (q.settle == q.cmd.dac) begin
               d.st = S_BURST;
               d.swing = 8'h00;
            end else if (tick) begin
               d.settle = q.settle + 8'd1;
            end
         end
         S_BURST: begin
            // One fast clock cycle stands for one carrier swing.
            d.swing = q.swing + 8'd1;
            if (q.swing == q.cmd.swings) begin
               d.conv = driver_current;
               if (hit) begin
                  wake[SRC_TAG] = 1'b1;
               end else if (last_burst) begin
                  wake[SRC_TIMEOUT] = 1'b1;
               end else begin
                  d.bursts = q.bursts + 5'd1;
                  d.st = S_GAP;
                  d.high_freq_osc = 1'b0;
                  d.tl = 8'h00;
                  d.unit = 9'd0;
               end
            end
         end
      endcase

      // External causes win a tie, since the host relies on them.
      if (q.st == S_GAP || q.st == S_OSC || q.st == S_DAC
            || q.st == S_BURST) begin
         if (pin_pulse && q.cmd.src[SRC_PIN]) begin
            wake = 8'h00;
            wake[SRC_PIN] = 1'b1;
         end else if (ss_pulse && q.cmd.src[SRC_SS]) begin
            wake = 8'h00;
            wake[SRC_SS] = 1'b1;
         end
      end

      // The first cause ends the wait and restores the leave setup.
      if (wake != 8'h00) begin
         d.ev = wake;
         d.st = S_READY;
         d.high_freq_osc = 1'b1;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Pin stages reset high, matching idle pins, so no false pulse.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.s1 <= 3'h7;
         q.s2 <= 3'h7;
         q.s3 <= 3'h7;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Event register is the only readable address on the link.
   assign lnk.rd_data = (lnk.rd_addr == WAKE_EVENT_ADDR) ? q.ev
      : 8'h00;
   assign lnk.idle_ready = (q.st == S_READY);
   assign lnk.dev_ready = (q.st == S_READY);
   assign high_freq_osc_en = q.high_freq_osc;
   assign spi_selected = q.spi;
   assign conv_data = q.conv;
endmodule
`default_nettype wire

// File: logic/wake_host.sv
// Host end: AXI4-Lite registers that drive the wake pins and idle orders.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wake_host
   import wake_pkg::*;
#(
   parameter int unsigned WAKE_WAIT = WAKE_MAX_CYC
)(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [4:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [4:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Link to the device
   wake_if.host             lnk
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum logic [2:0] {H_OFF, H_PULSE, H_SETTLE, H_READY, H_AWAY}
      hstate_t;

   typedef struct packed {
      hstate_t    st;
      logic       aw_got;
      logic       w_got;
      logic [4:0] awa;
      logic [31:0] wd;
      logic [3:0] ws;
      logic       bv;
      logic [1:0] br;
      logic       rv;
      logic [1:0] rr;
      logic [31:0] rd;
      logic [8:0] src;
      logic [31:0] tim;
      logic [23:0] det;
      logic [21:0] cnt;
      logic [2:0] rdy;
      logic [7:0] ev;
      logic       evv;
      logic       boot;
      logic       hib;
      logic       cal;
      logic       go;
      logic [7:0] cal_hi;
      logic [7:0] ref_v;
      logic       wake_n;
      logic       ss_n;
      logic       ivalid;
      idle_cmd_t  cmd;
   } host_t;

   host_t q;
   host_t d;
   logic  [31:0] merged;

   // Applies the byte enables of a write to an old word.
   function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      d = q;
      d.rdy = {q.rdy[1:0], lnk.dev_ready};
      merged = 32'h0;
      if (awvalid && awready) begin
         d.aw_got = 1'b1;
         d.awa = awaddr;
      end
      if (wvalid && wready) begin
         d.w_got = 1'b1;
         d.wd = wdata;
         d.ws = wstrb;
      end
      if (q.bv && bready) begin
         d.bv = 1'b0;
      end
      if (q.rv && rready) begin
         d.rv = 1'b0;
      end
      // Register writes; control bits act only in a fitting state.
      if (q.aw_got && q.w_got && !q.bv) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bv = 1'b1;
         d.br = 2'b00;
         unique case (q.awa)
            REG_CTRL: begin
               if (q.ws[0] && q.wd[CTRL_WAKE] && q.st != H_PULSE) begin
                  d.st = H_PULSE;
                  d.boot = (q.st == H_OFF);
                  d.cnt = 22'd0;
                  d.wake_n = 1'b0;
               end else if (q.ws[0] && q.wd[CTRL_SS] && q.st == H_AWAY)
                     begin
                  d.st = H_PULSE;
                  d.boot = 1'b0;
                  d.cnt = 22'd0;
                  d.ss_n = 1'b0;
               end else if (q.ws[0] && q.st == H_READY) begin
                  d.go = q.wd[CTRL_IDLE] | q.wd[CTRL_CAL];
                  d.cal = q.wd[CTRL_CAL];
                  d.cal_hi = CAL_HI_START;
               end
            end
            REG_SRC: begin
               merged = merge({23'h0, q.src}, q.wd, q.ws);
               d.src = merged[8:0];
            end
            REG_TIME: d.tim = merge(q.tim, q.wd, q.ws);
            REG_DET: begin
               merged = merge({8'h00, q.det}, q.wd, q.ws);
               d.det = merged[23:0];
            end
            default: d.br = 2'b10;
         endcase
      end
      if (arvalid && arready) begin
         d.rv = 1'b1;
         d.rr = 2'b00;
         unique case (araddr)
            REG_SRC: d.rd = {23'h0, q.src};
            REG_TIME: d.rd = q.tim;
            REG_DET: d.rd = {8'h00, q.det};
            REG_STATUS: d.rd = {8'h00, q.ref_v, q.ev, 5'h0, q.evv,
               q.cal, q.st == H_READY};
            default: begin
               d.rd = 32'h0;
               d.rr = (araddr == REG_CTRL) ? 2'b00 : 2'b10;
            end
         endcase
      end

      // Link sequencing.
      unique case (q.st)
         H_OFF: ;
         H_PULSE: begin
            d.cnt = q.cnt + 22'd1;
            if (q.cnt == 22'(PULSE_CYC - 1)) begin
               d.wake_n = 1'b1;
               d.ss_n = 1'b1;
               d.cnt = 22'd0;
               d.st = q.boot ? H_SETTLE : H_AWAY;
            end
         end
         H_SETTLE: begin
            d.cnt = q.cnt + 22'd1;
            if (q.cnt == 22'(WAKE_WAIT - 1)) begin
               d.st = H_READY;
               d.evv = 1'b0;
               d.hib = 1'b0;
            end
         end
         H_READY: begin
            if (q.go && !q.ivalid) begin
               d.ivalid = 1'b1;
               // Same gap, osc and dac fields for calibration and detection.
               d.cmd.gap = q.tim[7:0];
               d.cmd.osc = q.tim[15:8];
               d.cmd.dac = q.tim[23:16];
               d.cmd.lo = q.det[7:0];
               d.cmd.hi = q.det[15:8];
               d.cmd.swings = q.det[23:16];
               d.cmd.hib = q.src[8];
               d.cmd.src = q.src[7:0];
               d.cmd.src[SRC_PIN] = q.src[SRC_PIN] | ~q.src[SRC_SS];
               d.cmd.max_burst = {3'b000, q.tim[28:24]};
               if (q.tim[28:24] < MAX_BURST_LO) begin
                  d.cmd.max_burst = {3'b000, MAX_BURST_LO};
               end else if (q.tim[28:24] > MAX_BURST_HI) begin
                  d.cmd.max_burst = {3'b000, MAX_BURST_HI};
               end
               if (q.cal) begin
                  d.cmd.lo = 8'h00;
                  d.cmd.hi = q.cal_hi;
                  d.cmd.hib = 1'b0;
                  d.cmd.max_burst = {3'b000, MAX_BURST_LO};
                  d.cmd.src = 8'h0b;
               end
            end else if (q.ivalid && lnk.idle_ready) begin
               d.ivalid = 1'b0;
               d.go = 1'b0;
               d.hib = q.cmd.hib;
               d.st = H_AWAY;
            end
         end
         H_AWAY: begin
            // The event byte is sampled two cycles after the device reports ready.
            if (q.rdy[1] && !q.rdy[2]) begin
               d.st = H_READY;
               d.ev = lnk.rd_data;
               d.evv = !q.hib;
               if (q.cal) begin
                  if (lnk.rd_data[SRC_TAG]) begin
                     d.cal = 1'b0;
                     d.ref_v = q.cal_hi;
                     d.det[7:0] = q.cal_hi - GUARD;
                     d.det[15:8] = q.cal_hi + GUARD;
                  end else if (q.cal_hi == 8'h00) begin
                     d.cal = 1'b0;
                  end else begin
                     d.cal_hi = q.cal_hi - 8'd1;
                     d.go = 1'b1;
                  end
               end
            end
         end
      endcase
   end

   // ****************************************************************
   // Registers and outputs
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.wake_n <= 1'b1;
         q.ss_n <= 1'b1;
         q.src <= 9'h008;
      end else begin
         q <= d;
      end
   end

   assign awready = !q.aw_got && !q.bv;
   assign wready = !q.w_got && !q.bv;
   assign bvalid = q.bv;
   assign bresp = q.br;
   assign arready = !q.rv;
   assign rvalid = q.rv;
   assign rdata = q.rd;
   assign rresp = q.rr;
   assign lnk.wake_n = q.wake_n;
   assign lnk.ss_n = q.ss_n;
   assign lnk.idle_valid = q.ivalid;
   assign lnk.idle_cmd = q.cmd;
   assign lnk.rd_addr = WAKE_EVENT_ADDR;
endmodule
`default_nettype wire

// File: test/wake_event_controller_chk.sv
// Assertion checker watching the wake link between host and device.
`timescale 1ns/1ps
`default_nettype none
module wake_event_controller_chk
   import wake_pkg::*;
(
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Link signals
   input wire logic       wake_n,
   input wire logic       ss_n,
   input wire logic       idle_valid,
   input wire logic       idle_ready,
   input wire idle_cmd_t  idle_cmd,
   input wire logic [7:0] rd_data,
   // Device outputs
   input wire logic       high_freq_osc_en,
   input wire logic       spi_selected
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ****************************************************************
   // Helper state
   // ****************************************************************
   idle_cmd_t  cmd_q;
   logic [3:0] age_q;
   // Keep the order in force; power-up behaves like a pin-only wait.
   // A pulse acts only after it ends, so count cycles since pin low.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_q <= '{src: 8'h08, default: '0};
         age_q <= 4'hf;
      end else begin
         if (idle_valid && idle_ready)
            cmd_q <= idle_cmd;
         age_q <= !wake_n ? 4'h0 : age_q + {3'b0, age_q != 4'hf};
      end
   end
   // ****************************************************************
   // Properties
   // ****************************************************************
   sequence s_back;
      ##[1:6] idle_ready;
   endsequence
   sequence s_pin_end;
      $rose(wake_n) && !idle_ready;
   endsequence
   property p_take;
      idle_valid && idle_ready |=> !idle_ready;
   endproperty
   property p_hfo;
      idle_valid && idle_ready |-> ##[1:3] !high_freq_osc_en;
   endproperty
   property p_pin;
      s_pin_end ##0 (cmd_q.src[SRC_PIN] || cmd_q.hib) |-> s_back;
   endproperty
   property p_ss;
      $rose(ss_n) && !idle_ready && cmd_q.src[SRC_SS] && !cmd_q.hib
         |-> s_back;
   endproperty
   property p_hib;
      cmd_q.hib && !idle_ready && age_q == 4'hf |=> !idle_ready;
   endproperty
   property p_spi;
      $rose(idle_ready) |-> ##[0:1] spi_selected;
   endproperty
   property p_cause;
      $rose(idle_ready) |-> $onehot0(rd_data);
   endproperty
   property p_hold;
      idle_ready && $past(idle_ready) |-> $stable(rd_data);
   endproperty
   a_take: assert property (p_take)
      else $error("device stayed ready after idle order");
   a_hfo: assert property (p_hfo)
      else $error("fast oscillator left running while waiting");
   a_pin: assert property (p_pin)
      else $error("pin pulse did not bring ready");
   a_ss: assert property (p_ss)
      else $error("select pulse did not bring ready");
   a_hib: assert property (p_hib)
      else $error("hibernate left without pin pulse");
   a_spi: assert property (p_spi)
      else $error("ready without host interface selected");
   a_cause: assert property (p_cause)
      else $error("more than one wake cause recorded");
   a_hold: assert property (p_hold)
      else $error("wake event changed while ready");
endmodule
`default_nettype wire

// File: test/wake_event_controller_tb.sv
// Self-checking bench for the wake host and device facing each other.
`timescale 1ns/1ps
`default_nettype none
module wake_event_controller_tb;
   import wake_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, hfo_en, spi_sel;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [5:0]  dcur, conv;
   int          err_total, num_checks;
   wake_if lnk ();
   wake_dev wake_dev_inst (.aclk(aclk), .aresetn(aresetn), .lnk(lnk),
      .driver_current(dcur), .high_freq_osc_en(hfo_en),
      .spi_selected(spi_sel), .conv_data(conv));
   // A short wake wait keeps the run brief; the host still honours it.
   wake_host #(.WAKE_WAIT(20)) wake_host_inst (.aclk(aclk),
      .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .lnk(lnk));
   wake_event_controller_chk chk_inst (.aclk(aclk), .aresetn(aresetn),
      .wake_n(lnk.wake_n), .ss_n(lnk.ss_n), .idle_valid(lnk.idle_valid),
      .idle_ready(lnk.idle_ready), .idle_cmd(lnk.idle_cmd),
      .rd_data(lnk.rd_data), .high_freq_osc_en(hfo_en),
      .spi_selected(spi_sel));
   // Two unrelated clocks: fast system clock and slow oscillator.
   always #2 aclk = ~aclk;
   always #62.5 lnk.lfo_clk = ~lnk.lfo_clk;
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic print_verdict;
      if (err_total == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bail(input string nm);
      err_total++;
      $display("[ERR] %s expected done seen timeout", nm);
      print_verdict();
   endtask
   // Bus cycles start right after a rising edge and end on one.
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'b111;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) bail("write");
      check("bresp", 2'b00, bresp);
      // One idle edge keeps the next call from reassigning bready.
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 50) bail("read");
      // One idle edge keeps the next call from reassigning rready.
      @(posedge aclk);
   endtask
   // Counts slow oscillator rises until the device is ready again.
   task automatic wait_back(input int lim, output int e);
      logic p;
      int   n;
      e = 0;
      p = lnk.lfo_clk;
      for (n = 0; !lnk.idle_ready; n++) begin
         if (n == lim) bail("ready");
         @(posedge aclk);
         e += int'(lnk.lfo_clk && !p);
         p = lnk.lfo_clk;
      end
   endtask
   task automatic status(input logic v, input logic [7:0] ev);
      logic [31:0] d;
      logic [1:0]  r;
      // A known start value lets the poll loop run at all.
      d = 32'h0;
      for (int n = 0; n < 20 && !d[0]; n++)
         axi_rd(REG_STATUS, d, r);
      check("ready", 1'b1, d[0]);
      check("ev_valid", v, d[2]);
      if (v) check("event", ev, d[15:8]);
   endtask
   task automatic go_idle(input logic [31:0] src, tim, det);
      int n;
      axi_wr(REG_SRC, src);
      axi_wr(REG_TIME, tim);
      axi_wr(REG_DET, det);
      axi_wr(REG_CTRL, 32'h1);
      for (n = 0; lnk.idle_ready; n++) begin
         if (n == 20) bail("idle");
         @(posedge aclk);
      end
      repeat (4) @(posedge aclk);
      check("hfo_off", 1'b0, hfo_en);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic sc_powerup;
      logic [31:0] d;
      logic [1:0]  r;
      int          e;
      check("powerup", 1'b0, lnk.idle_ready);
      check("spi", 1'b0, spi_sel);
      axi_wr(REG_CTRL, 32'h2);
      wait_back(400, e);
      status(1'b0, 8'h00);
      check("spi", 1'b1, spi_sel);
      axi_rd(5'h14, d, r);
      check("unmapped", 2'b10, r);
   endtask
   // External wake while waiting; 0x0a also arms tag detection.
   task automatic sc_ext(input logic [31:0] src, ctl, input logic [7:0] ev);
      int e;
      go_idle(src, 32'h01010100, 32'h3f8010);
      axi_wr(REG_CTRL, ctl);
      wait_back(400, e);
      status(1'b1, ev);
   endtask
   task automatic sc_hib;
      int e;
      go_idle(32'h118, 32'h01010100, 32'h0);
      axi_wr(REG_CTRL, 32'h4);
      repeat (300) @(posedge aclk);
      check("hib_stay", 1'b0, lnk.idle_ready);
      axi_wr(REG_CTRL, 32'h2);
      wait_back(400, e);
      status(1'b0, 8'h00);
   endtask
   // Gap 0 and two periods: 256 * 2 * 2 slow ticks before timeout.
   task automatic sc_timer;
      int e;
      go_idle(32'h009, 32'h01010100, 32'h0);
      wait_back(40000, e);
      check("timer_ticks", 1'b1, e >= 1018 && e <= 1030);
      status(1'b1, 8'h01);
   endtask
   // Window 0x10..0x80 against the current scaled by four.
   task automatic sc_tag(input logic [5:0] dc, input logic [7:0] ev,
                         input int lo, hi);
      int e;
      dcur <= dc;
      go_idle(32'h00b, 32'h01010100, 32'h3f8010);
      wait_back(40000, e);
      check("tag_ticks", 1'b1, e >= lo && e <= hi);
      status(1'b1, ev);
      check("conv", dc, conv);
   endtask
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, dcur} = '0;
      wstrb = 4'hf;
      lnk.lfo_clk = 1'b0;
      err_total = 0;
      num_checks = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      sc_powerup();
      sc_ext(32'h008, 32'h2, 8'h08);
      sc_ext(32'h010, 32'h4, 8'h10);
      sc_ext(32'h00a, 32'h2, 8'h08);
      sc_hib();
      sc_timer();
      sc_tag(6'h30, 8'h02, 510, 522);
      sc_tag(6'h08, 8'h01, 1020, 1044);
      print_verdict();
   end
endmodule
`default_nettype wire
